// ### src/flash_ctl_map.svh
// register bit positions, opcodes, reset values and internal cycle counts
`ifndef FLASH_CTL_MAP_SVH
`define FLASH_CTL_MAP_SVH
`define ST_BUSY 0
`define ST_WEL 1
`define ST_BP_LO 2
`define ST_BP_HI 5
`define ST_PINDIS 6
`define ST_SRP 7
`define SS_ERASE_SUSP 2
`define SS_PROG_SUSP 3
`define NV_RESET 8'h00
`define OP_WRITE_ENABLE_CMD 8'h06
`define OP_WRITE_DISABLE_CMD 8'h04
`define OP_STATUS_READ_CMD 8'h05
`define OP_SUSPEND_STATUS_READ_CMD 8'h09
`define OP_STATUS_WRITE_CMD 8'h01
`define OP_PP 8'h02
`define OP_SUSP 8'hb0
`define OP_RESUME 8'h30
`define OP_SE 8'h20
`define OP_BE 8'hd8
`define OP_CE1 8'hc7
`define OP_CE2 8'h60
`define OP_DP 8'hb9
`define OP_WAKE 8'hab
`define OP_OTP_IN 8'h3a
`define OP_READ 8'h03
`define CYC_STATUS_WRITE_CMD 16'd400
`define CYC_PP 16'd700
`define CYC_ERASE 16'd4000
`endif

// ### src/flash_ctl_pkg.sv
// types for the serial flash command and protection block
package flash_ctl_pkg;
    typedef enum logic [3:0] {
        IDLE_S = 4'b0001,
        RUN_S = 4'b0010,
        SUSP_S = 4'b0100,
        SLEEP_S = 4'b1000
    } core_state_t;
    typedef enum logic [1:0] {
        JOB_STATUS_WRITE_CMD = 2'd0,
        JOB_PROG = 2'd1,
        JOB_ERASE = 2'd2
    } job_kind_t;
    typedef struct packed {
        logic valid;
        logic [7:0] opcode;
        logic [23:0] addr;
        logic [7:0] data0;
        logic [15:0] bytes;
        logic aligned;
    } frame_t;
endpackage : flash_ctl_pkg

// ### src/flash_ctl.sv
// serial flash command decode, write protection, status and suspend logic
`timescale 1ns/1ps
`include "flash_ctl_map.svh"
//
// Contract
// - active while selected or cycle running
// - deep power-down ignores all but wake
// - busy flag set during internal cycles
// - modifying commands need write enable latch
// - latch cleared at reset and completions
// - protect bits make region read-only
// - protect decode lower/upper block table
// - pin disable bit ignores protect pin
// - hardware mode freezes protect bits
// - otp lock bit blocks otp writes
// - otp status write sets lock bit
// - erase suspended flag set and cleared
// - program suspended flag set and cleared
// - msb first, sample on rising edge
// - only status read commands stream data out
// - write commands need byte-aligned frame end
// - partial program byte does nothing
// - short program or wake ignored
// - erase needs exact 24-bit address
// - array access ignored while busy
// - status read repeats until deselect
// - output shifts on falling clock
module flash_ctl #(
    parameter int BLOCKS = 64
) (
    // system clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // spi pins from the host
    input wire logic sel_n_in,
    input wire logic sck_in,
    input wire logic mosi_in,
    input wire logic wprot_n_in,
    output logic miso_out,
    output logic miso_oe_out,
    // state towards the array
    output logic active_out,
    output logic busy_out,
    output logic [7:0] status_out,
    output logic [7:0] susp_status_out,
    // accepted array jobs through a two-entry buffer
    output logic job_valid_out,
    input wire logic job_ready_in,
    output logic [1:0] job_kind_out,
    output logic [23:0] job_addr_out
);
    // two-stage synchronisers on the pins
    logic [3:0] pin_s1_r, pin_s2_r;
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            // idle pin levels, so no false clock edge follows reset
            pin_s1_r <= 4'h9;
            pin_s2_r <= 4'h9;
        end else begin
            pin_s1_r <= {sel_n_in, sck_in, mosi_in, wprot_n_in};
            pin_s2_r <= pin_s1_r;
        end
    end
    logic sel_n, sck, mosi, wprot_n, sck_d_r, sel_d_r;
    assign {sel_n, sck, mosi, wprot_n} = pin_s2_r;
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            sck_d_r <= 1'b0;
            sel_d_r <= 1'b1;
        end else begin
            sck_d_r <= sck;
            sel_d_r <= sel_n;
        end
    end
    logic rise, fall, frame_end;
    assign rise = !sel_n && sck && !sck_d_r;
    assign fall = !sel_n && !sck && sck_d_r;
    assign frame_end = sel_n && !sel_d_r;

    // input shifter, msb first on rising clock
    logic [2:0] bit_cnt_r;
    logic [15:0] byte_cnt_r;
    logic [7:0] sh_r, opcode_r, data0_r;
    logic [23:0] addr_r;
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            bit_cnt_r <= 3'd0;
            byte_cnt_r <= 16'd0;
            sh_r <= 8'h00;
            opcode_r <= 8'h00;
            addr_r <= 24'h000000;
            data0_r <= 8'h00;
        end else if (sel_n) begin
            bit_cnt_r <= 3'd0;
            if (frame_end) byte_cnt_r <= byte_cnt_r;
            else byte_cnt_r <= 16'd0;
        end else if (rise) begin
            sh_r <= {sh_r[6:0], mosi};
            bit_cnt_r <= bit_cnt_r + 3'd1;
            if (bit_cnt_r == 3'd7) begin
                if (byte_cnt_r != 16'hffff) byte_cnt_r <= byte_cnt_r + 16'd1;
                case (byte_cnt_r)
                    16'd0: opcode_r <= {sh_r[6:0], mosi};
                    16'd1: addr_r[23:16] <= {sh_r[6:0], mosi};
                    16'd2: addr_r[15:8] <= {sh_r[6:0], mosi};
                    16'd3: addr_r[7:0] <= {sh_r[6:0], mosi};
                    16'd4: data0_r <= {sh_r[6:0], mosi};
                    default: ;
                endcase
                if (byte_cnt_r == 16'd1) data0_r <= {sh_r[6:0], mosi};
            end
        end
    end
    flash_ctl_pkg::frame_t fr;
    assign fr = '{valid: frame_end, opcode: opcode_r, addr: addr_r, data0: data0_r,
                  bytes: byte_cnt_r, aligned: (bit_cnt_r == 3'd0)};

    // protection registers and modes
    logic [3:0] bp_r;
    logic pindis_r, srp_r, wel_r, otp_r, otp_lock_r, esusp_r, psusp_r;
    flash_ctl_pkg::core_state_t st_r;
    flash_ctl_pkg::job_kind_t kind_r;
    logic [15:0] cyc_r;
    logic [7:0] status_write_cmd_val_r;
    logic hw_mode, busy;
    assign busy = (st_r == flash_ctl_pkg::RUN_S);
    assign hw_mode = srp_r && !wprot_n && !pindis_r;

    // block-protect region decode
    logic [5:0] blk;
    logic prot_hit;
    assign blk = fr.addr[21:16];
    always_comb begin
        prot_hit = 1'b0;
        case (bp_r[2:0])
            3'd0: prot_hit = 1'b0;
            3'd7: prot_hit = 1'b1;
            default: prot_hit = bp_r[3] ? (blk >= 6'(1 << (bp_r[2:0] - 3'd1)))
                                        : (blk < 6'(BLOCKS - (1 << (bp_r[2:0] - 3'd1))));
        endcase
    end

    // acceptance of a finished frame
    logic wel_ok, aligned, do_write_enable_cmd, do_write_disable_cmd, do_status_write_cmd, do_pp, do_erase, do_ce, do_dp, do_wake;
    logic do_susp, do_resume, do_otp, sleeping, buf_ready;
    assign sleeping = (st_r == flash_ctl_pkg::SLEEP_S);
    // only idle takes new work, so a suspended job never loses its slot
    assign aligned = fr.valid && fr.aligned && st_r == flash_ctl_pkg::IDLE_S;
    assign wel_ok = wel_r;
    assign do_write_enable_cmd = aligned && fr.opcode == `OP_WRITE_ENABLE_CMD && fr.bytes == 16'd1;
    assign do_write_disable_cmd = aligned && fr.opcode == `OP_WRITE_DISABLE_CMD && fr.bytes == 16'd1;
    assign do_dp = aligned && fr.opcode == `OP_DP && fr.bytes == 16'd1;
    assign do_otp = aligned && fr.opcode == `OP_OTP_IN && fr.bytes == 16'd1;
    assign do_status_write_cmd = aligned && fr.opcode == `OP_STATUS_WRITE_CMD && fr.bytes == 16'd2 && wel_ok
                     && (otp_r || !hw_mode) && buf_ready;
    assign do_pp = aligned && fr.opcode == `OP_PP && fr.bytes >= 16'd5 && wel_ok
                   && (otp_r ? !otp_lock_r : !prot_hit) && buf_ready;
    assign do_erase = aligned && (fr.opcode == `OP_SE || fr.opcode == `OP_BE)
                      && fr.bytes == 16'd4 && wel_ok
                      && (otp_r ? !otp_lock_r : !prot_hit) && buf_ready;
    assign do_ce = aligned && (fr.opcode == `OP_CE1 || fr.opcode == `OP_CE2)
                   && fr.bytes == 16'd1 && wel_ok && bp_r[2:0] == 3'd0 && buf_ready;
    assign do_wake = fr.valid && sleeping && fr.opcode == `OP_WAKE && fr.bytes >= 16'd1;
    assign do_susp = fr.valid && busy && fr.opcode == `OP_SUSP && kind_r != flash_ctl_pkg::JOB_STATUS_WRITE_CMD;
    assign do_resume = fr.valid && st_r == flash_ctl_pkg::SUSP_S && fr.opcode == `OP_RESUME;

    // internal cycle sequencer and power state
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            st_r <= flash_ctl_pkg::IDLE_S;
            kind_r <= flash_ctl_pkg::JOB_STATUS_WRITE_CMD;
            cyc_r <= 16'd0;
        end else begin
            case (st_r)
                flash_ctl_pkg::IDLE_S: begin
                    if (do_dp) st_r <= flash_ctl_pkg::SLEEP_S;
                    else if (do_status_write_cmd || do_pp || do_erase || do_ce) begin
                        st_r <= flash_ctl_pkg::RUN_S;
                        kind_r <= do_status_write_cmd ? flash_ctl_pkg::JOB_STATUS_WRITE_CMD
                                : do_pp ? flash_ctl_pkg::JOB_PROG : flash_ctl_pkg::JOB_ERASE;
                        cyc_r <= do_status_write_cmd ? `CYC_STATUS_WRITE_CMD : do_pp ? `CYC_PP : `CYC_ERASE;
                    end
                end
                flash_ctl_pkg::RUN_S: begin
                    if (do_susp) st_r <= flash_ctl_pkg::SUSP_S;
                    else if (cyc_r <= 16'd1) st_r <= flash_ctl_pkg::IDLE_S;
                    else cyc_r <= cyc_r - 16'd1;
                end
                flash_ctl_pkg::SUSP_S: if (do_resume) st_r <= flash_ctl_pkg::RUN_S;
                flash_ctl_pkg::SLEEP_S: if (do_wake) st_r <= flash_ctl_pkg::IDLE_S;
                default: st_r <= flash_ctl_pkg::IDLE_S;
            endcase
        end
    end

    // suspend flags
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            esusp_r <= 1'b0;
            psusp_r <= 1'b0;
        end else if (do_susp) begin
            esusp_r <= (kind_r == flash_ctl_pkg::JOB_ERASE);
            psusp_r <= (kind_r == flash_ctl_pkg::JOB_PROG);
        end else if (do_resume) begin
            esusp_r <= 1'b0;
            psusp_r <= 1'b0;
        end
    end

    // write enable latch
    logic cyc_done;
    assign cyc_done = busy && !do_susp && cyc_r <= 16'd1;
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) wel_r <= 1'b0;
        else if (do_write_enable_cmd) wel_r <= 1'b1;
        else if (do_write_disable_cmd || cyc_done) wel_r <= 1'b0;
    end

    // non-volatile status bits, committed at the end of the write cycle
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            {srp_r, pindis_r, bp_r} <= 6'(`NV_RESET);
            otp_r <= 1'b0;
            otp_lock_r <= 1'b0;
            status_write_cmd_val_r <= 8'h00;
        end else begin
            if (do_otp) otp_r <= 1'b1;
            else if (do_write_disable_cmd) otp_r <= 1'b0;
            if (do_status_write_cmd) status_write_cmd_val_r <= fr.data0;
            if (cyc_done && kind_r == flash_ctl_pkg::JOB_STATUS_WRITE_CMD) begin
                if (otp_r) otp_lock_r <= 1'b1;
                else begin
                    bp_r <= status_write_cmd_val_r[`ST_BP_HI:`ST_BP_LO];
                    pindis_r <= status_write_cmd_val_r[`ST_PINDIS];
                    srp_r <= status_write_cmd_val_r[`ST_SRP];
                end
            end
        end
    end

    // status images
    always_comb begin
        status_out = {otp_r ? otp_lock_r : srp_r, pindis_r, bp_r, wel_r, busy};
        susp_status_out = 8'h00;
        susp_status_out[`SS_ERASE_SUSP] = esusp_r;
        susp_status_out[`SS_PROG_SUSP] = psusp_r;
    end
    assign busy_out = busy;
    assign active_out = !sel_n || busy;

    // output shifter on falling clock, status repeats until deselect
    logic [7:0] out_sh_r;
    logic out_en_r;
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            out_sh_r <= 8'h00;
            out_en_r <= 1'b0;
        end else if (sel_n) out_en_r <= 1'b0;
        else if (fall && bit_cnt_r == 3'd0 && byte_cnt_r != 16'd0 && !sleeping) begin
            out_en_r <= (opcode_r == `OP_STATUS_READ_CMD || opcode_r == `OP_SUSPEND_STATUS_READ_CMD);
            out_sh_r <= (opcode_r == `OP_SUSPEND_STATUS_READ_CMD) ? susp_status_out : status_out;
        end else if (fall && out_en_r) out_sh_r <= {out_sh_r[6:0], 1'b0};
    end
    assign miso_out = out_sh_r[7];
    assign miso_oe_out = out_en_r;

    // two-entry job buffer towards the array
    logic [25:0] buf_q [2];
    logic [1:0] cnt_r;
    logic push, pop;
    assign buf_ready = (cnt_r != 2'd2);
    assign push = do_pp || do_erase || do_ce || do_status_write_cmd;
    assign pop = job_valid_out && job_ready_in;
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            cnt_r <= 2'd0;
            buf_q[0] <= 26'h0;
            buf_q[1] <= 26'h0;
        end else begin
            if (pop) buf_q[0] <= buf_q[1];
            if (push) buf_q[(pop ? cnt_r - 2'd1 : cnt_r) == 2'd0 ? 0 : 1] <=
                {do_status_write_cmd ? 2'd0 : do_pp ? 2'd1 : 2'd2, fr.addr};
            cnt_r <= cnt_r + 2'(push) - 2'(pop);
        end
    end
    assign job_valid_out = (cnt_r != 2'd0);
    assign {job_kind_out, job_addr_out} = buf_q[0];

    // checks
    a_wel_gate_pp: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        $rose(busy_out) |-> $past(wel_r)) else $error("cycle started without latch");
    a_busy_after_go: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (st_r == flash_ctl_pkg::IDLE_S && do_erase) |=> busy_out) else $error("no busy");
    a_sleep_hold: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (sleeping && !do_wake) |=> sleeping) else $error("left sleep");
    a_wel_clear_end: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        cyc_done |=> !wel_r) else $error("latch kept");
    a_prot_refuse: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (prot_hit && !otp_r) |-> !do_pp && !do_erase) else $error("protected write");
    a_hw_freeze: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (hw_mode && !otp_r) |-> !do_status_write_cmd) else $error("frozen bits written");
    a_susp_flag: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (do_susp && kind_r == flash_ctl_pkg::JOB_ERASE) |=> esusp_r) else $error("no flag");
    a_psusp_flag: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        do_resume |=> !psusp_r && !esusp_r) else $error("flag kept");
    a_align_need: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (fr.valid && !fr.aligned) |-> !push) else $error("ragged frame taken");
    c_prog: cover property (@(posedge clk_in) do_pp);
    c_susp: cover property (@(posedge clk_in) do_susp);
    c_sleep: cover property (@(posedge clk_in) do_wake);
    c_full: cover property (@(posedge clk_in) !buf_ready);
endmodule : flash_ctl

// ### sim/spi_host.sv
// host spi master model, mode 0, driving the flash pins
`timescale 1ns/1ps
module spi_host (
    // spi pins towards the flash
    output logic sel_n_out,
    output logic sck_out,
    output logic mosi_out,
    input wire logic miso_in
);
    // half period of 4 clk keeps sck well below clk/4
    localparam int HALF_NS = 100;

    // idle: deselected, clock parked low
    initial begin
        sel_n_out = 1'b1;
        sck_out = 1'b0;
        mosi_out = 1'b0;
    end

    // one frame: nbits sent from the left of tx, then nrd bits read back
    task automatic xfer(input logic [47:0] tx, input int nbits, input int nrd, output logic [15:0] rx);
        rx = 16'h0000;
        #(HALF_NS) sel_n_out = 1'b0;
        for (int i = 0; i < nbits; i++) begin
            mosi_out = tx[47 - i];
            #(HALF_NS) sck_out = 1'b1;
            #(HALF_NS) sck_out = 1'b0;
        end
        // released line must not keep showing the last bit
        mosi_out = ~mosi_out;
        for (int i = 0; i < nrd; i++) begin
            #(HALF_NS) sck_out = 1'b1;
            rx = {rx[14:0], miso_in};
            #(HALF_NS) sck_out = 1'b0;
        end
        #(HALF_NS) sel_n_out = 1'b1;
        #(4 * HALF_NS);
    endtask : xfer
endmodule : spi_host

// ### sim/testbench.sv
// self-checking bench for the flash command, protection and status block
`timescale 1ns/1ps
`include "flash_ctl_map.svh"
module testbench;
    logic clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic wprot_n_in = 1'b1;
    logic job_ready_in = 1'b0;
    logic sel_n, sck, mosi, miso_out, miso_oe_out, active_out, busy_out, job_valid_out;
    logic [7:0] status_out, susp_status_out, op;
    logic [1:0] job_kind_out, last_kind;
    logic [23:0] job_addr_out, last_addr;
    logic [15:0] rx;
    logic [3:0] code;
    int errors = 0;
    int total_checks = 0;
    int pops = 0;
    logic oe_seen = 1'b0;
    int prot_blk[12] = '{62, 61, 59, 55, 47, 31, 1, 2, 4, 8, 16, 32};
    int open_blk[12] = '{63, 62, 60, 56, 48, 32, 0, 1, 3, 7, 15, 31};

    always #12.5 clk_in = ~clk_in;

    flash_ctl #(.BLOCKS(64)) i_flash_ctl (.clk_in(clk_in), .reset_n_in(reset_n_in), .sel_n_in(sel_n),
        .sck_in(sck), .mosi_in(mosi), .wprot_n_in(wprot_n_in), .miso_out(miso_out),
        .miso_oe_out(miso_oe_out), .active_out(active_out), .busy_out(busy_out), .status_out(status_out),
        .susp_status_out(susp_status_out), .job_valid_out(job_valid_out), .job_ready_in(job_ready_in),
        .job_kind_out(job_kind_out), .job_addr_out(job_addr_out));
    spi_host host (.sel_n_out(sel_n), .sck_out(sck), .mosi_out(mosi), .miso_in(miso_out));

    // record each job that leaves the buffer
    always @(posedge clk_in) begin
        if (job_valid_out === 1'b1 && job_ready_in === 1'b1) begin
            pops++;
            last_kind = job_kind_out;
            last_addr = job_addr_out;
        end
        if (miso_oe_out === 1'b1) oe_seen = 1'b1;
    end

    task automatic check(input string name, input logic [23:0] exp, input logic [23:0] got);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic results;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : results

    task automatic frame(input logic [47:0] tx, input int nbits, input int nrd);
        @(negedge clk_in);
        host.xfer(tx, nbits, nrd, rx);
        @(negedge clk_in);
    endtask : frame

    task automatic cmd(input logic [7:0] opc);
        frame({opc, 40'h0}, 8, 0);
    endtask : cmd

    // polls busy under a bound instead of waiting the worst case
    task automatic wait_idle(input int limit);
        int n;
        n = 0;
        while (busy_out !== 1'b0 && n < limit) begin
            @(negedge clk_in);
            n++;
        end
        check("idle", 24'h0, {23'h0, busy_out});
    endtask : wait_idle

    task automatic wsr(input logic [7:0] d);
        cmd(`OP_WRITE_ENABLE_CMD);
        frame({`OP_STATUS_WRITE_CMD, d, 32'h0}, 16, 0);
        wait_idle(500);
    endtask : wsr

    // watchdog well beyond the expected 73k cycles
    initial begin
        #(2_500_000);
        errors++;
        results();
    end

    initial begin
        repeat (3) @(negedge clk_in);
        reset_n_in = 1'b1;
        repeat (3) @(negedge clk_in);
        check("status", 24'h00, status_out);
        check("susp", 24'h00, susp_status_out);
        frame({`OP_PP, 24'h000100, 8'ha5, 8'h0}, 40, 0);
        check("no_wel", 24'h00, status_out);
        frame({`OP_WRITE_ENABLE_CMD, 40'h0}, 7, 0);
        frame({`OP_WRITE_ENABLE_CMD, 40'h0}, 9, 0);
        check("write_enable_cmd_odd", 24'h00, status_out);
        cmd(`OP_WRITE_ENABLE_CMD);
        check("write_enable_cmd", 24'h02, status_out);
        frame({`OP_PP, 24'h000100, 16'h0}, 32, 0);
        frame({`OP_PP, 24'h000100, 8'ha5, 8'ha0}, 43, 0);
        check("pp_bad", 24'h02, status_out);
        // job buffer stalled until job_ready_in is raised
        frame({`OP_PP, 24'h000100, 8'ha5, 8'h0}, 40, 0);
        check("pp_busy", 24'h03, status_out);
        check("active", 24'h1, {23'h0, active_out});
        check("jvalid", 24'h1, {23'h0, job_valid_out});
        check("job_kind", 24'h1, {22'h0, job_kind_out});
        check("job_addr", 24'h000100, job_addr_out);
        check("oe_quiet", 24'h0, {23'h0, oe_seen});
        frame({`OP_STATUS_READ_CMD, 40'h0}, 8, 16);
        check("status_read_cmd", 24'h0303, {8'h0, rx});
        check("oe_read", 24'h1, {23'h0, oe_seen});
        check("oe_off", 24'h0, {23'h0, miso_oe_out});
        frame({`OP_SE, 24'h000000, 16'h0}, 32, 0);
        cmd(`OP_SUSP);
        check("psusp", 24'h08, susp_status_out);
        cmd(`OP_RESUME);
        check("pres", 24'h00, susp_status_out);
        wait_idle(1000);
        check("pp_done", 24'h00, status_out);
        check("standby", 24'h0, {23'h0, active_out});
        cmd(`OP_WRITE_ENABLE_CMD);
        frame({`OP_PP, 24'h000200, 8'h5a, 8'h0}, 40, 0);
        wait_idle(800);
        cmd(`OP_WRITE_ENABLE_CMD);
        frame({`OP_PP, 24'h000300, 8'h5a, 8'h0}, 40, 0);
        check("full", 24'h02, status_out);
        job_ready_in = 1'b1;
        repeat (4) @(negedge clk_in);
        check("pops", 24'd2, 24'(pops));
        check("order", 24'h000200, last_addr);
        cmd(`OP_WRITE_DISABLE_CMD);
        check("write_disable_cmd", 24'h00, status_out);
        cmd(`OP_WRITE_ENABLE_CMD);
        frame({`OP_SE, 16'h0, 24'h0}, 24, 0);
        frame({`OP_SE, 32'h0, 8'h0}, 40, 0);
        check("se_len", 24'h02, status_out);
        // every partial protect code: edge block refused, neighbour erased
        for (int k = 0; k < 12; k++) begin
            code = (k < 6) ? 4'(k + 1) : 4'(k + 3);
            op = (k % 2) ? `OP_BE : `OP_SE;
            wsr({2'b00, code, 2'b00});
            check("bp", {16'h0, 2'b00, code, 2'b00}, status_out);
            cmd(`OP_WRITE_ENABLE_CMD);
            frame({op, 8'(prot_blk[k]), 32'h0}, 32, 0);
            check("prot", {16'h0, 2'b00, code, 2'b10}, status_out);
            frame({op, 8'(open_blk[k]), 32'h0}, 32, 0);
            check("open", {16'h0, 2'b00, code, 2'b11}, status_out);
            check("ekind", 24'h2, {22'h0, last_kind});
            check("eaddr", {8'(open_blk[k]), 16'h0}, last_addr);
            if (k == 0) begin
                cmd(`OP_SUSP);
                check("esusp", 24'h04, susp_status_out);
                cmd(`OP_RESUME);
                check("eres", 24'h00, susp_status_out);
            end
            wait_idle(4200);
        end
        wsr(8'h80);
        check("srp", 24'h80, status_out);
        wprot_n_in = 1'b0;
        wsr(8'h00);
        check("hpm", 24'h82, status_out);
        wprot_n_in = 1'b1;
        wsr(8'hc0);
        wprot_n_in = 1'b0;
        wsr(8'h00);
        check("pindis", 24'h00, status_out);
        cmd(`OP_DP);
        cmd(`OP_WRITE_ENABLE_CMD);
        check("asleep", 24'h00, status_out);
        frame({`OP_WAKE, 40'h0}, 32, 0);
        cmd(`OP_WRITE_ENABLE_CMD);
        check("awake", 24'h02, status_out);
        // protect bits are clear before otp entry
        cmd(`OP_OTP_IN);
        // unlocked secure sector programs like any other
        cmd(`OP_WRITE_ENABLE_CMD);
        frame({`OP_PP, 24'h000000, 8'h11, 8'h0}, 40, 0);
        check("otp_open", 24'h03, status_out);
        wait_idle(800);
        wsr(8'h1c);
        check("otp_lock", 24'h80, status_out);
        cmd(`OP_WRITE_ENABLE_CMD);
        frame({`OP_PP, 24'h000000, 8'h11, 8'h0}, 40, 0);
        check("otp_prog", 24'h82, status_out);
        cmd(`OP_WRITE_DISABLE_CMD);
        results();
    end
endmodule : testbench
